// ==== ars_consts.svh ====
// Constants for the axis run-status monitor: register offsets,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ARS_CONSTS_SVH
`define ARS_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ARS_OFF_CMD      6'h00
`define ARS_OFF_MODE     6'h04
`define ARS_OFF_MCMD     6'h08
`define ARS_OFF_RANGE    6'h0C
`define ARS_OFF_POSREF   6'h10
`define ARS_OFF_MREF     6'h14
`define ARS_OFF_ZERO     6'h18
`define ARS_OFF_AXIS_RUN_STATUS   6'h20
`define ARS_OFF_DRVSTS   6'h24
`define ARS_OFF_STS1     6'h28
`define ARS_OFF_LATCH    6'h2C
`define ARS_OFF_CURPOS   6'h30

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ARS_CMD_ABS_REQ    10
`define ARS_CMD_LATCH_REQ  13
`define ARS_MODE_POS       0
`define ARS_MODE_ZRN       3
`define ARS_MODE_FLAGS_HI  4
`define ARS_MODE_SERVO_ON  5
`define ARS_MODE_USE_MCMD  6
`define ARS_MODE_DIR_REV   8
`define ARS_MODE_PRM_ERR   9
`define ARS_MODE_PRM_CHG   10
`define ARS_RS_RUNNING     8
`define ARS_RS_DIR         9
`define ARS_RS_ABS_DONE    10
`define ARS_RS_LATCH_DONE  11
`define ARS_RS_NO_FB       12
`define ARS_RS_POS_DONE    13
`define ARS_RS_UNUSED      14
`define ARS_RS_ZRN_DONE    15
`define ARS_S1_RX_ERR      4
`define ARS_S1_RUN_READY   7
`define ARS_DS_ALARM       0
`define ARS_DS_WARN        1
`define ARS_CSW_DIST_DONE  2

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define ARS_RST_W32        32'h0000_0000
`define ARS_RST_W16        16'h0000
`define ARS_MCMD_NOP       16'h0000
`define ARS_MASK_W16       32'h0000_FFFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ARS_CLK_MHZ        10
`define ARS_SCAN_US        100
`define ARS_SCAN_CYCLES    (`ARS_SCAN_US * `ARS_CLK_MHZ)

`endif

// ==== ars_pkg.sv ====
// Types shared by the axis run-status monitor.
// Assumes ars_consts.svh is on the include path.
package ars_pkg;
  `include "ars_consts.svh"

  // Register bus handshake phase
  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} ars_bus_state_t;

  // One register word
  typedef logic [31:0] ars_word_t;
endpackage

// ==== ars_pin_sync.sv ====
// Pin input synchroniser: three shift flip-flops and an output flip-flop per bit, a change is
// accepted once the second and third stage agree.
// Assumes pins are asynchronous to ref_clk.
`timescale 1ns/1ps
module ars_pin_sync
  import ars_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         srst,
  // Pins in, filtered level out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_d;

  // Per-bit agreement filter
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_comb
      begin
        level_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : level_q[g];
      end
    end
  endgenerate

  // Shift stages
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end
    else
    begin
      s1_q    <= pin_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

endmodule

// ==== ars_axis_run_status_monitor.sv ====
// Axis run-status monitor: status flags of one motion axis, the
// drive-status pass-through and an Avalon-MM register slave.
// Assumes current position and command status come from logic on
// ref_clk; drive status, feedback, latch and encoder pins are async.
`timescale 1ns/1ps
`include "ars_consts.svh"
module ars_axis_run_status_monitor
  import ars_pkg::*;
#(
  parameter int SCAN_CYCLES = `ARS_SCAN_CYCLES
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Drive and encoder pins
  input  wire logic [15:0] drive_status_pin,
  input  wire logic        feedback_pulse_pin,
  input  wire logic        latch_input_pin,
  input  wire logic        abs_data_done_pin,
  input  wire logic        abs_data_error_pin,
  // Same-clock motion logic
  input  wire logic [31:0] current_position,
  input  wire logic [15:0] command_status_word,
  // Axis control outputs
  output logic             servo_on_out,
  output logic             axis_move_enable
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [19:0] pins_s;
  logic [15:0] drv_s;
  logic [3:0]  ev_s;
  logic [3:0]  ev_prev_q;
  logic [3:0]  ev_rise;

  ars_pin_sync #(.W(20)) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .pin_in  ({abs_data_error_pin, abs_data_done_pin, latch_input_pin,
               feedback_pulse_pin, drive_status_pin}),
    .level_q (pins_s)
  );

  // Split synchronised pins and find rising edges
  assign drv_s   = pins_s[15:0];
  assign ev_s    = pins_s[19:16];
  assign ev_rise = ev_s & ~ev_prev_q;

  // ----------------------------------------------------------------
  // Scan timer
  // ----------------------------------------------------------------
  logic [15:0] scan_cnt_q;
  logic [15:0] scan_cnt_d;
  logic        scan_tick;

  // Free-running scan divider
  always_comb
  begin
    scan_tick  = (scan_cnt_q == 16'(SCAN_CYCLES - 1));
    scan_cnt_d = scan_tick ? 16'h0000 : scan_cnt_q + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  ars_bus_state_t bus_st_q;
  ars_bus_state_t bus_st_d;
  logic           wait_d;
  ars_word_t      rdata_d;
  ars_word_t      rd_mux;
  logic           wr_now;

  ars_word_t cmd_q,  cmd_d;
  ars_word_t mode_q, mode_d;
  ars_word_t mcmd_q, mcmd_d;
  ars_word_t rng_q,  rng_d;
  ars_word_t pref_q, pref_d;
  ars_word_t mref_q, mref_d;
  ars_word_t zero_q, zero_d;
  logic [15:0] run_sts_q, run_sts_d;
  logic [15:0] drv_sts_q, drv_sts_d;
  logic [15:0] sts1_q,    sts1_d;
  ars_word_t   latch_pos_q, latch_pos_d;

  // Byte-lane merge for writes
  function automatic ars_word_t be_merge(ars_word_t old_w, ars_word_t new_w,
                                         logic [3:0] be);
    ars_word_t r;
    for (int i = 0; i < 4; i++)
      r[i*8 +: 8] = be[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
    return r;
  endfunction

  // Read multiplexer, unmapped addresses read zero
  always_comb
  begin
    case (avs_address)
      `ARS_OFF_CMD:    rd_mux = cmd_q;
      `ARS_OFF_MODE:   rd_mux = mode_q;
      `ARS_OFF_MCMD:   rd_mux = mcmd_q;
      `ARS_OFF_RANGE:  rd_mux = rng_q;
      `ARS_OFF_POSREF: rd_mux = pref_q;
      `ARS_OFF_MREF:   rd_mux = mref_q;
      `ARS_OFF_ZERO:   rd_mux = zero_q;
      `ARS_OFF_AXIS_RUN_STATUS: rd_mux = {16'h0000, run_sts_q};
      `ARS_OFF_DRVSTS: rd_mux = {16'h0000, drv_sts_q};
      `ARS_OFF_STS1:   rd_mux = {16'h0000, sts1_q};
      `ARS_OFF_LATCH:  rd_mux = latch_pos_q;
      `ARS_OFF_CURPOS: rd_mux = current_position;
      default:         rd_mux = `ARS_RST_W32;
    endcase
  end

  // One wait cycle, then a one-cycle acknowledge
  always_comb
  begin
    bus_st_d = bus_st_q;
    rdata_d  = avs_readdata;
    case (bus_st_q)
      BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          bus_st_d = BUS_ACK;
          rdata_d  = avs_read ? rd_mux : `ARS_RST_W32;
        end
      end
      BUS_ACK:  bus_st_d = BUS_IDLE;
      default:  bus_st_d = BUS_IDLE;
    endcase
    wait_d = (bus_st_d != BUS_ACK);
    wr_now = (bus_st_q == BUS_ACK) && avs_write;
  end

  // Writable registers, narrow ones keep upper bits zero
  always_comb
  begin
    cmd_d  = cmd_q;
    mode_d = mode_q;
    mcmd_d = mcmd_q;
    rng_d  = rng_q;
    pref_d = pref_q;
    mref_d = mref_q;
    zero_d = zero_q;
    if (wr_now)
    begin
      case (avs_address)
        `ARS_OFF_CMD:    cmd_d  = be_merge(cmd_q, avs_writedata, avs_byteenable)
                                  & `ARS_MASK_W16;
        `ARS_OFF_MODE:   mode_d = be_merge(mode_q, avs_writedata, avs_byteenable)
                                  & `ARS_MASK_W16;
        `ARS_OFF_MCMD:   mcmd_d = be_merge(mcmd_q, avs_writedata, avs_byteenable)
                                  & `ARS_MASK_W16;
        `ARS_OFF_RANGE:  rng_d  = be_merge(rng_q, avs_writedata, avs_byteenable)
                                  & `ARS_MASK_W16;
        `ARS_OFF_POSREF: pref_d = be_merge(pref_q, avs_writedata, avs_byteenable);
        `ARS_OFF_MREF:   mref_d = be_merge(mref_q, avs_writedata, avs_byteenable);
        `ARS_OFF_ZERO:   zero_d = be_merge(zero_q, avs_writedata, avs_byteenable);
        default:         cmd_d  = cmd_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Axis status logic
  // ----------------------------------------------------------------
  logic abs_done_q, abs_done_d;
  logic rx_err_q,   rx_err_d;
  logic latch_dn_q, latch_dn_d;
  logic fb_seen_q,  fb_seen_d;
  logic lock_q,     lock_d;
  logic nop_held_q, nop_held_d;
  logic srv_on_d,   move_en_d;
  logic abs_req, latch_req, abs_busy, run_ready, running, alarm, mcmd_nop;
  logic pos_mode, zrn_mode, use_mcmd, pos_done, zrn_done;

  // Absolute distance of two positions compared against the range
  function automatic logic in_range(ars_word_t a, ars_word_t b, logic [15:0] r);
    logic [32:0] d;
    d = {a[31], a} - {b[31], b};
    if (d[32])
      d = 33'h0 - d;
    return d <= {17'h00000, r};
  endfunction

  // Combinational condition terms
  always_comb
  begin
    abs_req   = cmd_q[`ARS_CMD_ABS_REQ];
    latch_req = cmd_q[`ARS_CMD_LATCH_REQ];
    alarm     = drv_s[`ARS_DS_ALARM];
    mcmd_nop  = (mcmd_q[15:0] == `ARS_MCMD_NOP);
    pos_mode  = mode_q[`ARS_MODE_POS];
    zrn_mode  = mode_q[`ARS_MODE_ZRN];
    use_mcmd  = mode_q[`ARS_MODE_USE_MCMD];
    abs_busy  = abs_req && !abs_done_q && !rx_err_q;
    run_ready = !mode_q[`ARS_MODE_PRM_ERR] && !mode_q[`ARS_MODE_PRM_CHG]
                && !abs_busy && !rx_err_q;
    running   = run_ready && (|mode_q[`ARS_MODE_FLAGS_HI:0])
                && mode_q[`ARS_MODE_SERVO_ON];
    if (use_mcmd)
      pos_done = pos_mode && command_status_word[`ARS_CSW_DIST_DONE]
                 && in_range(current_position, mref_q, rng_q[15:0]);
    else
      pos_done = pos_mode
                 && in_range(current_position, pref_q, rng_q[15:0]);
    zrn_done  = zrn_mode
                && in_range(current_position, zero_q, rng_q[15:0]);
  end

  // Event flags, held while their request stands, cleared when it drops
  always_comb
  begin
    latch_pos_d = latch_pos_q;
    abs_done_d  = abs_req && (abs_done_q || ev_rise[2]);
    rx_err_d    = abs_req && (rx_err_q || ev_rise[3]);
    latch_dn_d  = latch_req && (latch_dn_q || ev_rise[1]);
    if (latch_req && !latch_dn_q && ev_rise[1])
      latch_pos_d = current_position;
  end

  // Feedback activity per scan and alarm lockout of motion
  always_comb
  begin
    fb_seen_d  = scan_tick ? ev_rise[0] : (fb_seen_q || ev_rise[0]);
    nop_held_d = nop_held_q && mcmd_nop;
    lock_d     = lock_q;
    if (scan_tick)
    begin
      nop_held_d = mcmd_nop;
      if (nop_held_q && mcmd_nop && !alarm)
        lock_d = 1'b0;
    end
    if (running && pos_mode && use_mcmd && alarm)
      lock_d = 1'b1;
    srv_on_d  = scan_tick ? running : servo_on_out;
    move_en_d = srv_on_d && !lock_d;
  end

  // Published status words, refreshed once per scan
  always_comb
  begin
    run_sts_d = run_sts_q;
    drv_sts_d = drv_sts_q;
    sts1_d    = sts1_q;
    if (scan_tick)
    begin
      run_sts_d                     = `ARS_RST_W16;
      run_sts_d[`ARS_RS_RUNNING]    = running;
      run_sts_d[`ARS_RS_DIR]        = mode_q[`ARS_MODE_DIR_REV];
      run_sts_d[`ARS_RS_ABS_DONE]   = abs_done_q;
      run_sts_d[`ARS_RS_LATCH_DONE] = latch_dn_q;
      run_sts_d[`ARS_RS_NO_FB]      = !(fb_seen_q || ev_rise[0]);
      run_sts_d[`ARS_RS_POS_DONE]   = pos_done;
      run_sts_d[`ARS_RS_UNUSED]     = 1'b0;
      run_sts_d[`ARS_RS_ZRN_DONE]   = zrn_done;
      drv_sts_d                     = drv_s;
      sts1_d                        = `ARS_RST_W16;
      sts1_d[`ARS_S1_RX_ERR]        = rx_err_q;
      sts1_d[`ARS_S1_RUN_READY]     = run_ready;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      scan_cnt_q       <= 16'h0000;
      ev_prev_q        <= 4'h0;
      bus_st_q         <= BUS_IDLE;
      avs_waitrequest  <= 1'b1;
      avs_readdata     <= `ARS_RST_W32;
      {cmd_q, mode_q, mcmd_q, rng_q} <= '0;
      {pref_q, mref_q, zero_q, latch_pos_q} <= '0;
      {run_sts_q, drv_sts_q, sts1_q} <= '0;
      {abs_done_q, rx_err_q, latch_dn_q, fb_seen_q, lock_q, nop_held_q} <= '0;
      servo_on_out     <= 1'b0;
      axis_move_enable <= 1'b0;
    end
    else
    begin
      scan_cnt_q       <= scan_cnt_d;
      ev_prev_q        <= ev_s;
      bus_st_q         <= bus_st_d;
      avs_waitrequest  <= wait_d;
      avs_readdata     <= rdata_d;
      cmd_q            <= cmd_d;
      mode_q           <= mode_d;
      mcmd_q           <= mcmd_d;
      rng_q            <= rng_d;
      pref_q           <= pref_d;
      mref_q           <= mref_d;
      zero_q           <= zero_d;
      run_sts_q        <= run_sts_d;
      drv_sts_q        <= drv_sts_d;
      sts1_q           <= sts1_d;
      latch_pos_q      <= latch_pos_d;
      abs_done_q       <= abs_done_d;
      rx_err_q         <= rx_err_d;
      latch_dn_q       <= latch_dn_d;
      fb_seen_q        <= fb_seen_d;
      lock_q           <= lock_d;
      nop_held_q       <= nop_held_d;
      servo_on_out     <= srv_on_d;
      axis_move_enable <= move_en_d;
    end
  end

endmodule

// ==== ars_mon_chk.sv ====
// Port checks for the axis run-status monitor.
// Assumes SCAN_CYCLES of 8 and aligned register addresses.
`timescale 1ns/1ps
`include "ars_consts.svh"
module ars_mon_chk
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Axis control outputs
  input wire logic        servo_on_out,
  input wire logic        axis_move_enable
);
  // ----------------------------------------------------------------
  // Bus and status relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request left waiting");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_hole_zero: assert property (!avs_waitrequest && avs_read && avs_address == 6'h3C
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_spare: assert property (!avs_waitrequest && avs_read &&
    avs_address == `ARS_OFF_AXIS_RUN_STATUS |-> avs_readdata[31:16] == 16'h0 && !avs_readdata[14])
    else $error("run status spare bits set");
  a_drive_width: assert property (!avs_waitrequest && avs_read &&
    avs_address == `ARS_OFF_DRVSTS |-> avs_readdata[31:16] == 16'h0)
    else $error("drive status upper half set");
  a_run_scan: assert property ($changed(servo_on_out) |=> $stable(servo_on_out) [*7])
    else $error("run flag changed between scans");
  a_move_off: assert property ($fell(servo_on_out) |-> ##[0:1] !axis_move_enable)
    else $error("motion enabled after run dropped");
  a_move_run: assert property ($rose(axis_move_enable) |-> servo_on_out)
    else $error("motion enabled while not running");
endmodule

bind ars_axis_run_status_monitor ars_mon_chk ars_mon_chk_inst (
  .ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .servo_on_out, .axis_move_enable
);

// ==== ars_drive_model.sv ====
// Servo drive and encoder stand-in: status word, feedback pulses,
// latch input and absolute-data events.
// Assumes its tasks are called right after a rising edge of ref_clk.
`timescale 1ns/1ps
module ars_drive_model
(
  // Clock
  input  wire logic        ref_clk,
  // Drive and encoder lines
  output logic      [15:0] drive_status_pin,
  output logic             feedback_pulse_pin,
  output logic             latch_input_pin,
  output logic             abs_data_done_pin,
  output logic             abs_data_error_pin
);
  logic spin_q;
  int   ph;

  // Quiet lines at start
  initial
  begin
    drive_status_pin   = 16'h0000;
    feedback_pulse_pin = 1'b0;
    latch_input_pin    = 1'b0;
    abs_data_done_pin  = 1'b0;
    abs_data_error_pin = 1'b0;
    spin_q             = 1'b0;
    ph                 = 0;
  end

  // Feedback line toggles every third clock while turning, stands still otherwise
  always @(posedge ref_clk)
  begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (spin_q && ph == 2)
      feedback_pulse_pin <= ~feedback_pulse_pin;
  end

  task automatic spin(input logic on);
    spin_q <= on;
  endtask

  task automatic set_status(input logic [15:0] s);
    drive_status_pin <= s;
  endtask

  // Event pulse long enough for the pin filter: 0 latch, 1 data read, 2 read failed
  task automatic pulse(input int sel);
    case (sel)
      0:       latch_input_pin <= 1'b1;
      1:       abs_data_done_pin <= 1'b1;
      default: abs_data_error_pin <= 1'b1;
    endcase
    repeat (6) @(posedge ref_clk);
    latch_input_pin    <= 1'b0;
    abs_data_done_pin  <= 1'b0;
    abs_data_error_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the axis run-status monitor.
// Assumes the design, its package, the checker and the drive model.
`timescale 1ns/1ps
`include "ars_consts.svh"
module tb_top;
  import ars_pkg::*;
  localparam int         SCAN = 8;
  localparam logic [5:0] RS   = `ARS_OFF_AXIS_RUN_STATUS;
  localparam logic [5:0] S1   = `ARS_OFF_STS1;
  localparam logic [5:0] MD   = `ARS_OFF_MODE;
  localparam logic [5:0] CM   = `ARS_OFF_CMD;
  logic        ref_clk, srst, avs_read, avs_write, avs_waitrequest;
  logic        feedback_pulse_pin, latch_input_pin, abs_data_done_pin, abs_data_error_pin;
  logic        servo_on_out, axis_move_enable;
  logic [5:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, current_position, d;
  logic [15:0] drive_status_pin, command_status_word;
  int          error_cnt, checks, cyc;

  ars_axis_run_status_monitor #(.SCAN_CYCLES(SCAN)) ars_axis_run_status_monitor_inst (
    .ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .drive_status_pin,
    .feedback_pulse_pin, .latch_input_pin, .abs_data_done_pin, .abs_data_error_pin,
    .current_position, .command_status_word, .servo_on_out, .axis_move_enable
  );
  ars_drive_model ars_drive_model_inst (
    .ref_clk, .drive_status_pin, .feedback_pulse_pin, .latch_input_pin,
    .abs_data_done_pin, .abs_data_error_pin
  );

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("error_cnt=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] w);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= w;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    d = avs_readdata;
    if (n == 50)
      chk(32'h0, 32'h1);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic scans(input int n);
    repeat (n * SCAN) @(posedge ref_clk);
  endtask

  task automatic rbit(input logic [5:0] a, input int b, input logic v);
    bus(1'b0, a, 32'h0);
    chk({31'h0, d[b]}, {31'h0, v});
  endtask

  task automatic pt(input logic [31:0] cur, input int b, input logic v);
    current_position <= cur;
    scans(3);
    rbit(RS, b, v);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
    bus(1'b0, 6'h3C, 32'h0);
    chk(d, 32'h0);
    avs_byteenable <= 4'h5;
    bus(1'b1, `ARS_OFF_RANGE, 32'hAABB_CCDD);
    avs_byteenable <= 4'hF;
    bus(1'b0, `ARS_OFF_RANGE, 32'h0);
    chk(d, 32'h0000_00DD);
    bus(1'b1, RS, 32'h0000_FFFF);
    scans(3);
    bus(1'b0, RS, 32'h0);
    chk(d, 32'h0000_1000);
    bus(1'b0, S1, 32'h0);
    chk(d, 32'h0000_0080);
  endtask

  task automatic t_run();
    bus(1'b1, MD, 32'h0000_0121);
    ars_drive_model_inst.spin(1'b1);
    scans(3);
    rbit(RS, 8, 1'b1);
    rbit(RS, 9, 1'b1);
    rbit(RS, 12, 1'b0);
    chk({31'h0, servo_on_out}, 32'h1);
    ars_drive_model_inst.spin(1'b0);
    bus(1'b1, MD, 32'h0000_0321);
    scans(3);
    rbit(S1, 7, 1'b0);
    rbit(RS, 8, 1'b0);
    chk({31'h0, servo_on_out}, 32'h0);
    bus(1'b1, MD, 32'h0000_0020);
    scans(3);
    rbit(RS, 8, 1'b0);
    rbit(RS, 9, 1'b0);
  endtask

  task automatic t_abs();
    bus(1'b1, CM, 32'h0000_0400);
    scans(3);
    rbit(S1, 7, 1'b0);
    rbit(RS, 10, 1'b0);
    ars_drive_model_inst.pulse(1);
    scans(3);
    rbit(RS, 10, 1'b1);
    bus(1'b1, CM, 32'h0);
    bus(1'b1, CM, 32'h0000_0400);
    ars_drive_model_inst.pulse(2);
    scans(3);
    rbit(S1, 4, 1'b1);
    rbit(RS, 10, 1'b0);
    bus(1'b1, CM, 32'h0);
  endtask

  task automatic t_latch();
    current_position <= 32'h0000_1234;
    ars_drive_model_inst.pulse(0);
    scans(3);
    rbit(RS, 11, 1'b0);
    bus(1'b1, CM, 32'h0000_2000);
    ars_drive_model_inst.pulse(0);
    current_position <= 32'h0000_5678;
    scans(3);
    rbit(RS, 11, 1'b1);
    bus(1'b0, `ARS_OFF_LATCH, 32'h0);
    chk(d, 32'h0000_1234);
    bus(1'b1, CM, 32'h0);
  endtask

  task automatic t_pos();
    bus(1'b1, MD, 32'h0000_0001);
    bus(1'b1, `ARS_OFF_RANGE, 32'h0000_0005);
    bus(1'b1, `ARS_OFF_POSREF, 32'h0000_0064);
    pt(32'h0000_005E, 13, 1'b0);
    pt(32'h0000_005F, 13, 1'b1);
    pt(32'h0000_0069, 13, 1'b1);
    pt(32'h0000_006A, 13, 1'b0);
    bus(1'b1, MD, 32'h0000_0041);
    bus(1'b1, `ARS_OFF_MREF, 32'h0000_00C8);
    pt(32'h0000_00C8, 13, 1'b0);
    command_status_word <= 16'h0004;
    pt(32'h0000_00CD, 13, 1'b1);
    pt(32'h0000_00CE, 13, 1'b0);
    bus(1'b1, MD, 32'h0000_0008);
    bus(1'b1, `ARS_OFF_ZERO, 32'hFFFF_FFCE);
    pt(32'hFFFF_FFD3, 15, 1'b1);
    pt(32'hFFFF_FFD4, 15, 1'b0);
  endtask

  task automatic t_lock();
    current_position <= 32'h0;
    bus(1'b1, MD, 32'h0000_0061);
    bus(1'b1, `ARS_OFF_MCMD, 32'h0000_0001);
    scans(3);
    chk({31'h0, axis_move_enable}, 32'h1);
    ars_drive_model_inst.set_status(16'h0003);
    scans(3);
    bus(1'b0, `ARS_OFF_DRVSTS, 32'h0);
    chk(d, 32'h0000_0003);
    chk({31'h0, axis_move_enable}, 32'h0);
    ars_drive_model_inst.set_status(16'h0000);
    scans(3);
    chk({31'h0, axis_move_enable}, 32'h0);
    bus(1'b1, `ARS_OFF_MCMD, 32'h0);
    scans(3);
    bus(1'b1, `ARS_OFF_MCMD, 32'h0000_0001);
    chk({31'h0, axis_move_enable}, 32'h1);
  endtask

  // Reset in mid-run returns registers and flags to idle
  task automatic t_rst();
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk({31'h0, servo_on_out}, 32'h0);
    bus(1'b0, MD, 32'h0);
    chk(d, 32'h0);
    scans(3);
    rbit(RS, 8, 1'b0);
    bus(1'b0, S1, 32'h0);
    chk(d, 32'h0000_0080);
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Cut a hang short well beyond the expected run
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      conclude();
    end
  end

  initial
  begin
    srst                = 1'b1;
    avs_address         = 6'h00;
    avs_read            = 1'b0;
    avs_write           = 1'b0;
    avs_writedata       = 32'h0;
    avs_byteenable      = 4'hF;
    current_position    = 32'h0;
    command_status_word = 16'h0000;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_run();
    t_abs();
    t_latch();
    t_pos();
    t_lock();
    t_rst();
    conclude();
  end
endmodule
